/* serial_adc_ctrl.sv */
// Control and serial interface of an 8-bit successive-approximation converter.
module serial_adc_ctrl #(
  parameter int CHANNELS = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Serial link pins.
  input wire logic selectN,
  input wire logic convClk,
  input wire logic serialIn,
  input wire logic lsbFirstShiftN,
  output logic serialOut,
  output logic serialOutEnN,
  output logic conversionActive,
  // Analog front end.
  input wire logic comparatorHigh,
  output logic [serial_adc_pkg::RESULT_W-1:0] dacCode,
  output logic [CHANNELS-1:0] posSel,
  output logic [CHANNELS:0] negSel,
  output logic samplePos,
  output logic sampleNeg,
  // Result for local use.
  output logic [serial_adc_pkg::RESULT_W-1:0] result,
  output logic resultValid
);
  import serial_adc_pkg::*;

  // Address word length and shift-enable presence follow the channel count.
  localparam logic [2:0] ADDR_BITS = (CHANNELS == 8) ? 3'h4 : ((CHANNELS == 4) ? 3'h3 : 3'h0);
  localparam bit HAS_SHIFT_EN = (CHANNELS == 8);
  localparam bit HAS_LSB_REPEAT = (CHANNELS != 1);

  conv_state_e stateQ, stateD;
  logic clkPrevQ;
  logic riseEdge, fallEdge;
  logic [ADDR_REG_W-1:0] addrQ, addrD;
  logic [2:0] cntQ, cntD;
  logic [RESULT_W-1:0] sarQ, sarD;
  logic [RESULT_W-1:0] shiftQ, shiftD;
  logic firstQ, firstD;
  logic doQ, doD;
  logic oeNQ, oeND;
  logic activeQ, activeD;
  logic samplePosQ, samplePosD;
  logic sampleNegQ, sampleNegD;
  logic validQ, validD;
  logic singleEnded;
  logic [CHAN_CODE_W-1:0] chanCode;
  logic [2:0] bitIdx;

  // The converter clock pin is synchronous to clk_sys, so a one-stage history finds its edges.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      clkPrevQ <= convClk; // Tracks the pin, so a high idle level is not taken for a rise.
    end else begin
      clkPrevQ <= convClk;
    end
  end

  assign riseEdge = convClk && !clkPrevQ;
  assign fallEdge = !convClk && clkPrevQ;
  assign bitIdx = 3'h7 - cntQ;

  // Address fields; the word arrives select-mode bit first, so it lands MSB first here.
  generate
    if (CHANNELS == 8) begin : g_addr8
      assign singleEnded = addrQ[3];
      assign chanCode = {addrQ[1], addrQ[0], addrQ[2]};
    end else if (CHANNELS == 4) begin : g_addr4
      assign singleEnded = addrQ[2];
      assign chanCode = {1'b0, addrQ[0], addrQ[1]};
    end else begin : g_addr1
      assign singleEnded = 1'b0;
      assign chanCode = 3'h0;
    end
  endgenerate

  // Multiplexer enables come straight from this conversion's address word.
  mux_channel_decode #(
    .CHANNELS(CHANNELS)
  ) u_decode (
    .singleEnded(singleEnded),
    .chanCode(chanCode),
    .posSel(posSel),
    .negSel(negSel)
  );

  // Sequencer next-state: every action is tied to one edge of the converter clock.
  always_comb begin
    stateD = stateQ;
    addrD = addrQ;
    cntD = cntQ;
    sarD = sarQ;
    shiftD = shiftQ;
    firstD = firstQ;
    doD = doQ;
    oeND = oeNQ;
    activeD = activeQ;
    samplePosD = 1'b0;
    sampleNegD = 1'b0;
    validD = validQ;
    unique case (stateQ)
      ST_IDLE: begin
        // Zeros before the start bit change nothing.
        if (riseEdge && serialIn) begin
          cntD = COUNT_RESET;
          stateD = (ADDR_BITS == 3'h0) ? ST_ACQ : ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (riseEdge) begin
          addrD = {addrQ[ADDR_REG_W-2:0], serialIn};
          cntD = cntQ + 3'h1;
          if (cntQ + 3'h1 == ADDR_BITS) begin
            cntD = COUNT_RESET;
            stateD = ST_ACQ;
          end
        end
      end
      ST_ACQ: begin
        // Half a period after the last address bit: sample plus input, go busy.
        if (fallEdge) begin
          activeD = 1'b1;
          samplePosD = 1'b1;
          oeND = 1'b0;
          doD = 1'b0;
          firstD = 1'b1;
          sarD = RESULT_RESET;
          stateD = ST_CONV;
        end
      end
      ST_CONV: begin
        // Serial input is no longer looked at from here on.
        if (riseEdge) begin
          sarD[bitIdx] = 1'b1;
          sampleNegD = firstQ;
          firstD = 1'b0;
        end else if (fallEdge) begin
          // A minus input above the plus input fails every trial, giving zero.
          sarD[bitIdx] = comparatorHigh;
          doD = comparatorHigh;
          if (cntQ == LAST_SHIFT) begin
            shiftD = {sarQ[RESULT_W-1:1], comparatorHigh};
            validD = 1'b1;
            cntD = COUNT_RESET;
            stateD = ST_FINISH;
          end else begin
            cntD = cntQ + 3'h1;
          end
        end
      end
      ST_FINISH: begin
        // Busy drops half a clock after the eighth decision.
        if (riseEdge) begin
          activeD = 1'b0;
          stateD = HAS_LSB_REPEAT ? ST_LSBOUT : ST_DONE;
          // Without a reversed stream the line goes low as soon as busy drops.
          if (!HAS_LSB_REPEAT) begin
            doD = 1'b0;
          end
        end
      end
      ST_LSBOUT: begin
        // The LSB already on the line starts the reversed stream.
        if (fallEdge && !(HAS_SHIFT_EN && lsbFirstShiftN)) begin
          if (cntQ == LAST_SHIFT) begin
            doD = 1'b0;
            stateD = ST_DONE;
          end else begin
            doD = shiftQ[1];
            shiftD = {1'b0, shiftQ[RESULT_W-1:1]};
            cntD = cntQ + 3'h1;
          end
        end
      end
      ST_DONE: begin
        // Holds the line low until select goes high.
        if (fallEdge) begin
          doD = 1'b0;
        end
      end
      default: begin
        stateD = ST_IDLE;
      end
    endcase
  end

  // Select high acts as a clear for every register of the sequence.
  always_ff @(posedge clk_sys) begin
    if (srst || selectN) begin
      stateQ <= ST_IDLE;
      addrQ <= ADDR_RESET;
      cntQ <= COUNT_RESET;
      sarQ <= RESULT_RESET;
      shiftQ <= RESULT_RESET;
      firstQ <= 1'b0;
      doQ <= 1'b0;
      oeNQ <= 1'b1;
      activeQ <= 1'b0;
      samplePosQ <= 1'b0;
      sampleNegQ <= 1'b0;
      validQ <= 1'b0;
    end else begin
      stateQ <= stateD;
      addrQ <= addrD;
      cntQ <= cntD;
      sarQ <= sarD;
      shiftQ <= shiftD;
      firstQ <= firstD;
      doQ <= doD;
      oeNQ <= oeND;
      activeQ <= activeD;
      samplePosQ <= samplePosD;
      sampleNegQ <= sampleNegD;
      validQ <= validD;
    end
  end

  // Outputs, all from flip-flops.
  assign serialOut = doQ;
  assign serialOutEnN = oeNQ;
  assign conversionActive = activeQ;
  assign dacCode = sarQ;
  assign samplePos = samplePosQ;
  assign sampleNeg = sampleNegQ;
  assign result = shiftQ;
  assign resultValid = validQ;

  // Checks on the sequence.
  idle_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
    (stateQ == ST_IDLE && !selectN && riseEdge && !serialIn) |=> stateQ == ST_IDLE)
    else $error("Leading zero left the idle state.");

  addr_hiz_a: assert property (@(posedge clk_sys) disable iff (srst)
    (stateQ == ST_IDLE || stateQ == ST_ADDR) |-> serialOutEnN)
    else $error("Output driven during addressing.");

  busy_rise_a: assert property (@(posedge clk_sys) disable iff (srst)
    (stateQ == ST_ACQ && !selectN && fallEdge)
    |=> conversionActive && !serialOut && !serialOutEnN && samplePos)
    else $error("Busy flag or leading zero missing after acquisition.");

  busy_cause_a: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(conversionActive) |-> $past(stateQ) == ST_ACQ && $past(fallEdge))
    else $error("Busy flag rose without an acquisition edge.");

  msb_ship_a: assert property (@(posedge clk_sys) disable iff (srst)
    (stateQ == ST_CONV && !selectN && fallEdge) |=> serialOut == $past(comparatorHigh))
    else $error("Comparator decision not shipped on falling edge.");

  busy_drop_a: assert property (@(posedge clk_sys) disable iff (srst)
    (stateQ == ST_FINISH && !selectN && riseEdge) |=> !conversionActive && resultValid)
    else $error("Busy flag did not drop after the eighth decision.");

  addr_ignore_a: assert property (@(posedge clk_sys) disable iff (srst)
    (conversionActive && !selectN) |=> $stable(addrQ))
    else $error("Address changed while busy.");

  lsb_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    (HAS_SHIFT_EN && stateQ == ST_LSBOUT && lsbFirstShiftN && !selectN)
    |=> $stable(serialOut) && $stable(shiftQ))
    else $error("Output moved while shift-enable was high.");

  done_low_a: assert property (@(posedge clk_sys) disable iff (srst)
    (stateQ == ST_DONE) |-> !serialOut && !serialOutEnN)
    else $error("Output not held low after readout.");

  deselect_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
    selectN |=> stateQ == ST_IDLE && !conversionActive && serialOutEnN && addrQ == ADDR_RESET)
    else $error("Deselect did not clear the sequence.");

  neg_sample_a: assert property (@(posedge clk_sys) disable iff (srst)
    (stateQ == ST_CONV && !selectN && riseEdge && firstQ)
    |=> sampleNeg && dacCode[RESULT_W-1])
    else $error("Minus input not sampled on the first trial.");

  stream_end_a: assert property (@(posedge clk_sys) disable iff (srst)
    (stateQ == ST_LSBOUT && cntQ == LAST_SHIFT && fallEdge && !selectN
     && !(HAS_SHIFT_EN && lsbFirstShiftN)) |=> stateQ == ST_DONE && !serialOut)
    else $error("Reversed stream did not end in a low line.");

endmodule

/* serial_adc_pkg.sv */
// Shared constants and state encoding for the serial converter control block.
package serial_adc_pkg;

  // Result width and number of successive-approximation steps.
  localparam int RESULT_W = 8;
  localparam int CONV_STEPS = 8;

  // Width of the captured address word register and the channel code.
  localparam int ADDR_REG_W = 4;
  localparam int CHAN_CODE_W = 3;

  // Values after a clear.
  localparam logic [RESULT_W-1:0] RESULT_RESET = 8'h00;
  localparam logic [ADDR_REG_W-1:0] ADDR_RESET = 4'h0;
  localparam logic [2:0] COUNT_RESET = 3'h0;

  // Index of the last result bit shifted out in the reversed stream.
  localparam logic [2:0] LAST_SHIFT = 3'h7;

  // Conversion sequence states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACQ = 3'b011,
    ST_CONV = 3'b010,
    ST_FINISH = 3'b110,
    ST_LSBOUT = 3'b111,
    ST_DONE = 3'b101
  } conv_state_e;

endpackage

/* mux_channel_decode.sv */
// Analog input multiplexer decoder: channel code to positive and negative enables.
module mux_channel_decode #(
  parameter int CHANNELS = 8
) (
  // Captured address fields.
  input wire logic singleEnded,
  input wire logic [serial_adc_pkg::CHAN_CODE_W-1:0] chanCode,
  // One-hot enables; the top bit of negSel is the common input.
  output logic [CHANNELS-1:0] posSel,
  output logic [CHANNELS:0] negSel
);
  import serial_adc_pkg::*;

  logic [CHAN_CODE_W-1:0] negCode;

  // Differential pairs are always adjacent, so the partner differs only in bit 0.
  assign negCode = {chanCode[CHAN_CODE_W-1:1], ~chanCode[0]};

  // One comparator per channel keeps the enables strictly one-hot.
  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    assign posSel[i] = (chanCode == CHAN_CODE_W'(i));
    assign negSel[i] = !singleEnded && (CHANNELS > 1) && (negCode == CHAN_CODE_W'(i));
  end

  // Single-ended mode references the common input.
  assign negSel[CHANNELS] = singleEnded || (CHANNELS == 1);

endmodule

/* adc_front_model.sv */
// Analog front end model: track/hold inputs and the comparator.
module adc_front_model (
  // Clock.
  input wire logic clk_sys,
  // Multiplexer enables, sample pulses and trial code.
  input wire logic [7:0] posSel,
  input wire logic [8:0] negSel,
  input wire logic samplePos,
  input wire logic sampleNeg,
  input wire logic [7:0] dacCode,
  // Comparator decision.
  output logic comparatorHigh
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] heldPos;
  logic [7:0] heldNeg;

  // Channel level as a code; bit 8 is the common input at ground.
  function automatic logic [7:0] level(input logic [8:0] sel);
    level = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (sel[i]) begin
        level = 8'h15 + 8'h1D * i[7:0];
      end
    end
  endfunction

  // Plus and minus inputs are held on their own pulses.
  always_ff @(posedge clk_sys) begin
    if (samplePos) begin
      heldPos <= level({1'b0, posSel});
    end
    if (sampleNeg) begin
      heldNeg <= level(negSel);
    end
  end

  // A negative difference never beats any trial, so the code ends at zero.
  assign comparatorHigh = (heldPos >= heldNeg) && ((heldPos - heldNeg) >= dacCode);
endmodule

/* serial_adc_ctrl_tb.sv */
// Self-checking bench for the serial converter control block.
module serial_adc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, srst, selectN, convClk, serialIn, lsbFirstShiftN, comparatorHigh;
  logic serialOut, serialOutEnN, conversionActive, samplePos, sampleNeg, resultValid;
  logic [7:0] dacCode, posSel, result;
  logic [8:0] negSel;
  logic [3:0] addrs [6];
  int mismatches, n_compared;

  serial_adc_ctrl #(.CHANNELS(8)) u_dut (.clk_sys(clk_sys), .srst(srst),
    .selectN(selectN), .convClk(convClk), .serialIn(serialIn),
    .lsbFirstShiftN(lsbFirstShiftN), .serialOut(serialOut), .serialOutEnN(serialOutEnN),
    .conversionActive(conversionActive), .comparatorHigh(comparatorHigh),
    .dacCode(dacCode), .posSel(posSel), .negSel(negSel), .samplePos(samplePos),
    .sampleNeg(sampleNeg), .result(result), .resultValid(resultValid));

  adc_front_model u_front (.clk_sys(clk_sys), .posSel(posSel), .negSel(negSel),
    .samplePos(samplePos), .sampleNeg(sampleNeg), .dacCode(dacCode),
    .comparatorHigh(comparatorHigh));

  // System clock, 20 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Compares one settled value and counts it.
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One converter clock period; the low phase is three cycles so outputs settle.
  task automatic tick(input logic din);
    serialIn = din;
    convClk = 1'b1;
    repeat (2) @(negedge clk_sys);
    convClk = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask

  // Expected code worked out from the address word and the model's levels.
  function automatic logic [7:0] expect_code(input logic [3:0] a);
    logic [7:0] p;
    logic [7:0] n;
    p = 8'h15 + 8'h1D * {5'h00, a[1:0], a[2]};
    n = a[3] ? 8'h00 : 8'h15 + 8'h1D * {5'h00, a[1:0], ~a[2]};
    return (p >= n) ? p - n : 8'h00;
  endfunction

  // Deselect and check that the output enable is released and busy and valid are cleared.
  task automatic deselect();
    selectN = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("enable", 8'h01, {7'h00, serialOutEnN});
    check("busy", 8'h00, {7'h00, conversionActive});
    check("valid", 8'h00, {7'h00, resultValid});
  endtask

  // Full conversion with both output streams; serialIn toggles while busy.
  task automatic convert(input logic [3:0] a, input int zeros, input logic hold);
    logic [7:0] got;
    logic [7:0] exp;
    exp = expect_code(a);
    lsbFirstShiftN = hold;
    selectN = 1'b0;
    repeat (zeros) tick(1'b0);
    tick(1'b1);
    for (int i = 3; i >= 0; i--) tick(a[i]);
    check("busy", 8'h01, {7'h00, conversionActive});
    check("enable", 8'h00, {7'h00, serialOutEnN});
    check("lead", 8'h00, {7'h00, serialOut});
    check("pos enable", 8'h01 << {a[1:0], a[2]}, posSel);
    check("neg enable", a[3] ? 8'h00 : 8'h01 << {a[1:0], ~a[2]}, negSel[7:0]);
    check("common", {7'h00, a[3]}, {7'h00, negSel[8]});
    for (int i = 7; i >= 0; i--) begin
      tick(~serialIn);
      got[i] = serialOut;
    end
    check("msb stream", exp, got);
    check("result", exp, result);
    check("valid", 8'h01, {7'h00, resultValid});
    // A held shift-enable keeps the LSB on the line; releasing it starts the stream.
    if (hold) begin
      repeat (3) begin
        tick(~serialIn);
        check("hold lsb", {7'h00, exp[0]}, {7'h00, serialOut});
      end
      lsbFirstShiftN = 1'b0;
    end
    for (int i = 1; i < 8; i++) begin
      tick(~serialIn);
      got[i] = serialOut;
      if (i == 1) check("busy low", 8'h00, {7'h00, conversionActive});
    end
    check("lsb stream", exp, got);
    tick(1'b0);
    check("tail", 8'h00, {7'h00, serialOut});
    check("tail enable", 8'h00, {7'h00, serialOutEnN});
    deselect();
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Reset, an aborted conversion, then a table of addresses.
  initial begin
    addrs = '{4'h8, 4'hF, 4'hC, 4'h1, 4'h5, 4'h6};
    srst = 1'b1;
    selectN = 1'b1;
    convClk = 1'b0;
    serialIn = 1'b0;
    lsbFirstShiftN = 1'b0;
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("reset enable", 8'h01, {7'h00, serialOutEnN});
    selectN = 1'b0;
    tick(1'b1);
    repeat (6) tick(1'b1);
    deselect();
    check("trial", 8'h00, dacCode);
    $display("Test abort done");
    for (int k = 0; k < 6; k++) begin
      convert(addrs[k], k % 3, k == 5);
      $display("Test %0d done", k);
    end
    results();
  end
endmodule
